// >>> include/front_panel_pkg.sv
package front_panel_pkg;
  // register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register byte addresses
  localparam logic [7:0] REG_CONTROL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_DISPLAY = 8'h08;
  localparam logic [7:0] REG_DECIMAL = 8'h0c;
  // control: bit 0 lets keys in
  localparam int CTRL_KEYS_BIT = 0;
  localparam logic CONTROL_RESET = 1'b1;
  // key codes: 5'h00..5'h0f are the hex data keys
  localparam logic [4:0] clear_key = 5'h10;
  localparam logic [4:0] halt_step_key = 5'h11;
  localparam logic [4:0] run_key = 5'h12;
  localparam logic [4:0] hex_to_dec_key = 5'h13;
  localparam logic [4:0] dec_to_hex_key = 5'h14;
  localparam logic [4:0] enter_workspace_key = 5'h15;
  localparam logic [4:0] show_workspace_key = 5'h16;
  localparam logic [4:0] enter_counter_key = 5'h17;
  localparam logic [4:0] show_counter_key = 5'h18;
  localparam logic [4:0] enter_status_key = 5'h19;
  localparam logic [4:0] show_status_key = 5'h1a;
  localparam logic [4:0] show_bitfield_key = 5'h1b;
  localparam logic [4:0] enter_bitfield_key = 5'h1c;
  localparam logic [4:0] set_memory_address_key = 5'h1d;
  localparam logic [4:0] write_memory_key = 5'h1e;
  localparam logic [4:0] write_memory_advance_key = 5'h1f;
  // host message command bytes (ascii)
  localparam logic [7:0] MSG_INIT_A = 8'h41;
  localparam logic [7:0] MSG_INIT_Z = 8'h5a;
  localparam logic [7:0] MSG_RD_WP = 8'h77;
  localparam logic [7:0] MSG_WR_WP = 8'h57;
  localparam logic [7:0] MSG_RD_PC = 8'h70;
  localparam logic [7:0] MSG_WR_PC = 8'h50;
  localparam logic [7:0] MSG_RD_ST = 8'h73;
  localparam logic [7:0] MSG_WR_ST = 8'h53;
  localparam logic [7:0] MSG_RD_MEM = 8'h6d;
  localparam logic [7:0] MSG_WR_MEM = 8'h4d;
  localparam logic [7:0] MSG_RD_FIELD = 8'h63;
  localparam logic [7:0] MSG_WR_FIELD = 8'h43;
  localparam logic [7:0] MSG_HALT_STEP = 8'h48;
  localparam logic [7:0] MSG_RUN = 8'h52;
  // message byte and answer byte counts
  localparam logic [2:0] TX_ONE = 3'd1;
  localparam logic [2:0] TX_TWO = 3'd2;
  localparam logic [2:0] TX_THREE = 3'd3;
  localparam logic [2:0] TX_FOUR = 3'd4;
  localparam logic [2:0] TX_FIVE = 3'd5;
  localparam logic [2:0] TX_SIX = 3'd6;
  localparam logic [2:0] RX_NONE = 3'd0;
  localparam logic [2:0] RX_WORD = 3'd2;
  localparam logic [2:0] RX_PAIR = 3'd4;
  // datapath constants
  localparam logic [3:0] FIELD_WIDE_MIN = 4'h9;
  localparam logic [15:0] ADDR_STEP = 16'h0002;
  localparam logic [19:0] MAX_POSITIVE = 20'h07fff;
  localparam logic [19:0] DEC_BASE = 20'd10;
  localparam logic [4:0] DABBLE_STEPS = 5'd16;
  localparam logic [4:0] DEC_DIGITS = 5'd5;
  localparam logic [3:0] BCD_ADJ_MIN = 4'h5;
  localparam logic [3:0] BCD_ADJ = 4'h3;
  // sequencer states, gray along idle-send-recv
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_RECV = 2'b11,
    ST_CONV = 2'b10
  } unit_state_t;
endpackage

// >>> rtl/front_panel_key_command_unit.sv
`timescale 1ns/1ps
module front_panel_key_command_unit (
  input wire logic clock,
  input wire logic rst,
  input wire logic [front_panel_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [front_panel_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [front_panel_pkg::DATA_W-1:0] reg_rdata,
  input wire logic key_valid,
  input wire logic [4:0] key_code,
  output logic key_ready,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  output logic [15:0] disp_left,
  output logic [15:0] disp_right,
  output logic [3:0] disp_fifth,
  output logic disp_negative,
  output logic disp_blank,
  output logic disp_run
);
  import front_panel_pkg::*;

  unit_state_t state; // sequencer state
  logic [47:0] tx_buf; // outgoing message, top byte first
  logic [2:0] tx_left; // bytes still to send
  logic [2:0] rx_left; // answer bytes still due
  logic [31:0] rx_shift; // answer bytes so far
  logic [4:0] op; // key that started the transfer
  logic adv_phase; // second half of write-and-advance
  logic [15:0] left; // left display field
  logic [19:0] right; // right field plus fifth digit
  logic negative; // decimal sign lamp
  logic blank; // display blanked
  logic run; // program running
  logic field_valid; // a bitfield request has been shown
  logic h2d_armed; // first hex-to-decimal press seen
  logic d2h_armed; // first decimal-to-hex press seen
  logic to_dec; // conversion direction in flight
  logic [4:0] conv_cnt; // conversion steps left
  logic [19:0] bcd; // bcd digits, or decimal accumulator
  logic [15:0] bin; // magnitude being dabbled
  logic [19:0] dsh; // decimal digits being consumed
  logic keys_enabled; // control bit

  // handshake and decode
  wire key_take = key_valid && key_ready;
  wire hex_key = !key_code[4];
  wire [31:0] rx_word = {rx_shift[23:0], rx_data};
  wire [3:0] field_cnt = left[15:12];
  wire field_small = (field_cnt != 4'h0) && (field_cnt < FIELD_WIDE_MIN);
  wire [15:0] field_out = field_small ? {8'h00, right[15:8]} : right[15:0];
  wire tx_fire = tx_valid && tx_ready;
  wire rx_last = (state == ST_RECV) && rx_valid && (rx_left == 3'd1);
  wire adv_first = rx_last && (op == write_memory_advance_key) && !adv_phase;
  wire finish = rx_last && !adv_first;
  wire [15:0] next_addr = left + ADDR_STEP;
  wire conv_go = key_take && ((key_code == hex_to_dec_key && h2d_armed) ||
                              (key_code == dec_to_hex_key && d2h_armed));
  wire conv_done = (state == ST_CONV) && (conv_cnt == 5'd0);
  wire [15:0] magnitude = right[15] ? (~right[15:0] + 16'h0001) : right[15:0];
  wire [19:0] dec_step = (bcd * DEC_BASE) + {16'h0000, dsh[19:16]};
  wire [19:0] clamped = (bcd > MAX_POSITIVE) ? MAX_POSITIVE : bcd;
  wire [19:0] adj;

  assign key_ready = (state == ST_IDLE) && keys_enabled;
  assign tx_valid = (state == ST_SEND);
  assign tx_data = tx_buf[47:40];
  assign disp_left = left;
  assign disp_right = right[15:0];
  assign disp_fifth = right[19:16];
  assign disp_negative = negative;
  assign disp_blank = blank;
  assign disp_run = run;

  // per-digit add-three of the binary to bcd dabble
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_dabble
      assign adj[4*g+3:4*g] = (bcd[4*g+3:4*g] >= BCD_ADJ_MIN) ?
                              (bcd[4*g+3:4*g] + BCD_ADJ) : bcd[4*g+3:4*g];
    end
  endgenerate

  // message chosen by the key just taken
  logic start_ok;
  logic [47:0] start_buf;
  logic [2:0] start_tx;
  logic [2:0] start_rx;
  always_comb begin
    start_ok = 1'b1;
    start_buf = 48'h0;
    start_tx = TX_ONE;
    start_rx = RX_NONE;
    unique case (key_code)
      enter_workspace_key: begin
        start_buf = {MSG_WR_WP, right[15:0], 24'h0};
        start_tx = TX_THREE;
      end
      show_workspace_key: begin
        start_buf = {MSG_RD_WP, 40'h0};
        start_rx = RX_WORD;
      end
      enter_counter_key: begin
        start_buf = {MSG_WR_PC, right[15:0], 24'h0};
        start_tx = TX_THREE;
      end
      show_counter_key: begin
        start_buf = {MSG_RD_PC, 40'h0};
        start_rx = RX_WORD;
      end
      enter_status_key: begin
        start_buf = {MSG_WR_ST, right[15:0], 24'h0};
        start_tx = TX_THREE;
      end
      show_status_key: begin
        start_buf = {MSG_RD_ST, 40'h0};
        start_rx = RX_WORD;
      end
      show_bitfield_key: begin // count digit, then 12-bit address
        start_buf = {MSG_RD_FIELD, 4'h0, right[15:12], 4'h0, right[11:0], 16'h0};
        start_tx = TX_FOUR;
        start_rx = RX_WORD;
      end
      enter_bitfield_key: begin // only after a show has set the request
        start_ok = field_valid;
        start_buf = {MSG_WR_FIELD, 4'h0, field_cnt, 4'h0, left[11:0], field_out};
        start_tx = TX_SIX;
      end
      set_memory_address_key: begin
        start_buf = {MSG_RD_MEM, right[15:0], 24'h0};
        start_tx = TX_THREE;
        start_rx = RX_WORD;
      end
      write_memory_key, write_memory_advance_key: begin // write answers read-back
        start_buf = {MSG_WR_MEM, left, right[15:0], 8'h0};
        start_tx = TX_FIVE;
        start_rx = RX_WORD;
      end
      halt_step_key: begin // answer is address then contents
        start_buf = {MSG_HALT_STEP, 40'h0};
        start_rx = RX_PAIR;
      end
      run_key: start_buf = {MSG_RUN, 40'h0};
      clear_key: begin
        start_buf = {MSG_INIT_A, MSG_INIT_Z, 32'h0};
        start_tx = TX_TWO;
      end
      default: start_ok = 1'b0; // hex and conversion keys stay local
    endcase
  end

  // sequencer: send message bytes, collect answer bytes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      tx_buf <= 48'h0;
      tx_left <= 3'd0;
      rx_left <= 3'd0;
      rx_shift <= 32'h0;
      op <= 5'h00;
      adv_phase <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (key_take && start_ok) begin
            tx_buf <= start_buf;
            tx_left <= start_tx;
            rx_left <= start_rx;
            op <= key_code;
            adv_phase <= 1'b0;
            state <= ST_SEND;
          end else if (conv_go) begin
            state <= ST_CONV;
          end
        end
        ST_SEND: begin
          if (tx_fire) begin
            tx_buf <= {tx_buf[39:0], 8'h00};
            tx_left <= tx_left - 3'd1;
            if (tx_left == 3'd1) begin
              state <= (rx_left != 3'd0) ? ST_RECV : ST_IDLE;
            end
          end
        end
        ST_RECV: begin
          if (rx_valid) begin
            rx_shift <= rx_word;
            rx_left <= rx_left - 3'd1;
          end
          if (adv_first) begin // read back the next word
            tx_buf <= {MSG_RD_MEM, next_addr, 24'h0};
            tx_left <= TX_THREE;
            rx_left <= RX_WORD;
            adv_phase <= 1'b1;
            state <= ST_SEND;
          end else if (rx_last) begin
            state <= ST_IDLE;
          end
        end
        ST_CONV: begin
          if (conv_done) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // conversion datapath: dabble for hex-to-dec, times ten for dec-to-hex
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      to_dec <= 1'b0;
      conv_cnt <= 5'd0;
      bcd <= 20'h0;
      bin <= 16'h0;
      dsh <= 20'h0;
    end else if (conv_go) begin
      to_dec <= (key_code == hex_to_dec_key);
      conv_cnt <= (key_code == hex_to_dec_key) ? DABBLE_STEPS : DEC_DIGITS;
      bcd <= 20'h0;
      bin <= magnitude;
      dsh <= right;
    end else if (state == ST_CONV && conv_cnt != 5'd0) begin
      conv_cnt <= conv_cnt - 5'd1;
      bcd <= to_dec ? {adj[18:0], bin[15]} : dec_step;
      bin <= {bin[14:0], 1'b0};
      dsh <= {dsh[15:0], 4'h0};
    end
  end

  // display fields and panel flags
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      left <= 16'h0;
      right <= 20'h0;
      negative <= 1'b0;
      blank <= 1'b1;
      run <= 1'b0;
      field_valid <= 1'b0;
      h2d_armed <= 1'b0;
      d2h_armed <= 1'b0;
    end else if (key_take) begin
      if (hex_key) begin // five digits kept in decimal entry
        right <= d2h_armed ? {right[15:0], key_code[3:0]} :
                             {4'h0, right[11:0], key_code[3:0]};
        blank <= 1'b0;
        negative <= 1'b0;
      end else if (key_code == clear_key) begin
        left <= 16'h0;
        right <= 20'h0;
        negative <= 1'b0;
        blank <= 1'b1;
        run <= 1'b0;
        field_valid <= 1'b0;
        h2d_armed <= 1'b0;
        d2h_armed <= 1'b0;
      end else if (key_code == hex_to_dec_key) begin
        h2d_armed <= !h2d_armed;
        d2h_armed <= 1'b0;
      end else if (key_code == dec_to_hex_key) begin
        d2h_armed <= !d2h_armed;
        h2d_armed <= 1'b0;
      end else if (key_code == show_bitfield_key) begin
        left <= right[15:0];
        field_valid <= 1'b1;
      end else if (key_code == set_memory_address_key) begin
        left <= right[15:0];
      end else if (key_code == run_key) begin
        run <= 1'b1;
      end else if (key_code == halt_step_key) begin
        run <= 1'b0;
      end
    end else if (adv_first) begin
      left <= next_addr;
    end else if (finish) begin
      if (op == halt_step_key) begin
        left <= rx_word[31:16];
        right <= {4'h0, rx_word[15:0]};
      end else if (op == show_bitfield_key && field_small) begin
        right <= {4'h0, rx_word[7:0], 8'h00};
      end else begin // registers, memory, wide fields
        right <= {4'h0, rx_word[15:0]};
      end
    end else if (conv_done) begin
      right <= to_dec ? bcd : {4'h0, clamped[15:0]};
      negative <= to_dec && right[15];
    end
  end

  // register port: control write, one-cycle read data
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      keys_enabled <= CONTROL_RESET;
      reg_rdata <= 32'h0;
    end else begin
      if (reg_write && reg_addr == REG_CONTROL) begin
        keys_enabled <= reg_wdata[CTRL_KEYS_BIT];
      end
      if (reg_read) begin
        unique case (reg_addr)
          REG_CONTROL: reg_rdata <= {31'h0, keys_enabled};
          REG_STATUS: reg_rdata <= {24'h0, field_valid, run, blank, negative,
                                    h2d_armed, d2h_armed, state};
          REG_DISPLAY: reg_rdata <= {left, right[15:0]};
          REG_DECIMAL: reg_rdata <= {11'h0, negative, right};
          default: reg_rdata <= 32'h0;
        endcase
      end else begin
        reg_rdata <= 32'h0;
      end
    end
  end

  property p_ws_write;
    @(posedge clock) disable iff (rst)
    key_take && key_code == enter_workspace_key
    |=> tx_valid && tx_data == MSG_WR_WP && tx_buf[39:24] == $past(right[15:0]);
  endproperty
  a_ws_write: assert property (p_ws_write) else $error("workspace write msg wrong");

  property p_hex_shift;
    @(posedge clock) disable iff (rst)
    key_take && hex_key && !d2h_armed
    |=> right[15:0] == {$past(right[11:0]), $past(key_code[3:0])};
  endproperty
  a_hex_shift: assert property (p_hex_shift) else $error("hex digit not shifted in");

  property p_clear_init;
    @(posedge clock) disable iff (rst)
    key_take && key_code == clear_key
    |=> blank && tx_data == MSG_INIT_A
    ##1 (tx_data == ($past(tx_ready) ? MSG_INIT_Z : MSG_INIT_A));
  endproperty
  a_clear_init: assert property (p_clear_init) else $error("clear did not send A then Z");

  property p_field_left;
    @(posedge clock) disable iff (rst)
    key_take && key_code == show_bitfield_key |=> left == $past(right[15:0]) && field_valid;
  endproperty
  a_field_left: assert property (p_field_left) else $error("bitfield request not moved left");

  property p_field_small;
    @(posedge clock) disable iff (rst)
    finish && op == show_bitfield_key && field_small
    |=> right[15:0] == {$past(rx_word[7:0]), 8'h00};
  endproperty
  a_field_small: assert property (p_field_small) else $error("small field not in left digits");

  property p_advance;
    @(posedge clock) disable iff (rst)
    adv_first |=> left == $past(left) + ADDR_STEP && tx_data == MSG_RD_MEM;
  endproperty
  a_advance: assert property (p_advance) else $error("address not advanced by two");

  property p_limit;
    @(posedge clock) disable iff (rst)
    conv_done && !to_dec |=> right[19:15] == 5'h00;
  endproperty
  a_limit: assert property (p_limit) else $error("decimal to hex result out of range");

  property p_field_gate;
    @(posedge clock) disable iff (rst)
    key_take && key_code == enter_bitfield_key && !field_valid |=> state == ST_IDLE;
  endproperty
  a_field_gate: assert property (p_field_gate) else $error("bitfield enter without request");

  property p_halt_step;
    @(posedge clock) disable iff (rst)
    key_take && key_code == halt_step_key |=> !run && tx_data == MSG_HALT_STEP;
  endproperty
  a_halt_step: assert property (p_halt_step) else $error("halt/step not issued");
endmodule

// >>> sim/host_model.sv
`timescale 1ns/1ps
// far side: the target microcomputer answering terminal messages
module host_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic slow
);
  import front_panel_pkg::*;
  logic [15:0] wp, pc, st; // target registers
  logic [15:0] mem [logic [15:0]]; // sparse memory, unwritten reads ~addr
  logic bits [logic [11:0]]; // serial bit space
  logic [7:0] msg [$]; // message being collected
  logic [7:0] ans [$]; // answer bytes still to send
  logic [7:0] log_q [$]; // every byte taken, for the bench
  logic tick; // stall pacing
  int gap; // cycles before next answer byte
  int cnt; // field bit count
  logic [15:0] a, d, v;

  // message length from its command byte
  function automatic int msg_len(input logic [7:0] c);
    case (c)
      MSG_WR_WP, MSG_WR_PC, MSG_WR_ST, MSG_RD_MEM: return 3;
      MSG_WR_MEM: return 5;
      MSG_RD_FIELD: return 4;
      MSG_WR_FIELD: return 6;
      default: return 1;
    endcase
  endfunction

  // memory read, rom from ff80 up ignores writes
  function automatic logic [15:0] rd(input logic [15:0] x);
    return mem.exists(x) ? mem[x] : ~x;
  endfunction

  // take bytes, decode, queue answers high byte first
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      msg.delete();
      ans.delete();
      tx_ready <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= 8'h5a;
      tick <= 1'b0;
      gap = 0;
    end else begin
      tick <= ~tick;
      tx_ready <= slow ? tick : 1'b1;
      if (ans.size() > 0 && gap == 0) begin // next answer byte
        rx_valid <= 1'b1;
        rx_data <= ans.pop_front();
        gap = slow ? 3 : 0;
      end else begin // idle line keeps moving
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
        if (gap > 0) gap--;
      end
      if (tx_valid && tx_ready) begin
        msg.push_back(tx_data);
        log_q.push_back(tx_data);
        if (msg.size() == msg_len(msg[0])) begin
          a = {msg[msg_len(msg[0]) == 6 ? 2 : 1], msg[msg_len(msg[0]) == 6 ? 3 : 2]};
          if (msg[0] == MSG_RD_FIELD || msg[0] == MSG_WR_FIELD) begin
            a = {msg[2], msg[3]};
            cnt = (msg[1][4:0] == 5'h00) ? 16 : int'(msg[1][4:0]);
          end
          d = (msg.size() >= 5) ? {msg[msg.size()-2], msg[msg.size()-1]} : 16'h0000;
          v = 16'h0000;
          gap = slow ? 6 : 1;
          case (msg[0])
            MSG_WR_WP: wp = a;
            MSG_WR_PC: pc = a;
            MSG_WR_ST: st = a;
            MSG_RD_WP: ans = '{wp[15:8], wp[7:0]};
            MSG_RD_PC: ans = '{pc[15:8], pc[7:0]};
            MSG_RD_ST: ans = '{st[15:8], st[7:0]};
            MSG_RD_MEM: ans = '{rd(a)>>8, rd(a)};
            MSG_WR_MEM: begin
              if (a < 16'hff80) mem[a] = d;
              ans = '{rd(a)>>8, rd(a)};
            end
            MSG_RD_FIELD: begin
              for (int i = 0; i < cnt; i++) v[i] = bits.exists(a[11:0]+i) ? bits[a[11:0]+i] : 1'b0;
              ans = '{v[15:8], v[7:0]};
            end
            MSG_WR_FIELD: for (int i = 0; i < cnt; i++) bits[a[11:0]+i] = d[i];
            MSG_HALT_STEP: begin
              pc = pc + 16'h0002;
              ans = '{pc[15:8], pc[7:0], rd(pc)>>8, rd(pc)};
            end
            default: ;
          endcase
          msg.delete();
        end
      end
    end
  end
endmodule

// >>> sim/testbench.sv
`timescale 1ns/1ps
`define CHECK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin err_total++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module testbench;
  import front_panel_pkg::*;
  logic clock, rst, reg_write, reg_read, key_valid, tx_ready, rx_valid, key_ready, tx_valid;
  logic disp_negative, disp_blank, disp_run, slow;
  logic [7:0] reg_addr, tx_data, rx_data;
  logic [31:0] reg_wdata, reg_rdata, rd;
  logic [4:0] key_code;
  logic [15:0] disp_left, disp_right, fv;
  logic [3:0] disp_fifth;
  int err_total = 0;
  int cmp_count = 0;
  int nlog;
  localparam logic [15:0] W = 16'hb6d3;
  localparam logic [15:0] RV [3] = '{16'hff00, 16'hfe00, 16'h2000};
  localparam logic [4:0] EK [3] = '{enter_workspace_key, enter_counter_key, enter_status_key};
  localparam logic [4:0] SK [3] = '{show_workspace_key, show_counter_key, show_status_key};
  localparam logic [4:0] CK [4] = '{dec_to_hex_key, dec_to_hex_key, hex_to_dec_key, hex_to_dec_key};
  localparam logic [19:0] CI [4] = '{20'h00045, 20'h99999, 20'h08000, 20'h07fff};
  localparam logic [19:0] CE [4] = '{20'h0002d, 20'h07fff, 20'h32768, 20'h32767};
  localparam int CN [4] = '{5, 5, 4, 4};

  front_panel_key_command_unit front_panel_key_command_unit_i (.clock(clock), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .key_valid(key_valid), .key_code(key_code), .key_ready(key_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_valid(rx_valid), .disp_left(disp_left), .disp_right(disp_right),
    .disp_fifth(disp_fifth), .disp_negative(disp_negative), .disp_blank(disp_blank),
    .disp_run(disp_run));
  host_model host_model_i (.clock(clock), .rst(rst), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .slow(slow));

  // 200 mhz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // verdict and end of run
  task automatic close_out;
    $display("mismatches %0d comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // register write, one strobe cycle
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  // register read, data sampled in the following cycle
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
  endtask

  // bounded wait for the unit to take keys
  task automatic wait_ready;
    int n;
    n = 0;
    @(negedge clock);
    while (key_ready !== 1'b1) begin
      n++;
      if (n > 4000) begin
        `CHECK(key_ready, 1'b1)
        close_out();
      end
      @(negedge clock);
    end
  endtask

  // one key pulse, then wait for completion
  task automatic press(input logic [4:0] k);
    wait_ready();
    @(posedge clock);
    key_valid <= 1'b1;
    key_code <= k;
    @(posedge clock);
    key_valid <= 1'b0;
    wait_ready();
    @(negedge clock);
  endtask

  // hex digits, most significant first
  task automatic enter(input logic [19:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) press({1'b0, v[4*i +: 4]});
  endtask

  // hang guard
  initial begin
    repeat (90000) @(posedge clock);
    `CHECK(1'b0, 1'b1)
    close_out();
  end

  // main sequence
  initial begin
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    key_valid = 1'b0;
    key_code = 5'h00;
    slow = 1'b0;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    `CHECK(disp_blank, 1'b1)
    reg_rd(REG_CONTROL, rd);
    `CHECK(rd[0], CONTROL_RESET)
    reg_rd(REG_STATUS, rd);
    `CHECK(rd, 32'h00000020)
    reg_rd(8'h10, rd);
    `CHECK(rd, 32'h0)
    reg_wr(REG_CONTROL, 32'h0);
    @(negedge clock);
    `CHECK(key_ready, 1'b0)
    reg_wr(REG_CONTROL, 32'h1);
    // clear, then a field write with no field shown is dropped
    press(5'h07);
    `CHECK(disp_blank, 1'b0)
    press(clear_key);
    `CHECK(disp_right, 16'h0000)
    `CHECK(host_model_i.log_q[$-1], MSG_INIT_A)
    `CHECK(host_model_i.log_q[$], MSG_INIT_Z)
    `CHECK(disp_blank, 1'b1)
    nlog = host_model_i.log_q.size();
    press(enter_bitfield_key);
    `CHECK(host_model_i.log_q.size(), nlog)
    enter(20'h12345, 5);
    `CHECK(disp_right, 16'h2345)
    // target registers against a stalling host
    slow <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      enter(RV[i], 4);
      press(EK[i]);
      fv = (i == 0) ? host_model_i.wp : (i == 1) ? host_model_i.pc : host_model_i.st;
      `CHECK(fv, RV[i])
      enter(20'h0, 4);
      press(SK[i]);
      `CHECK(disp_right, RV[i])
    end
    slow <= 1'b0;
    // memory address, write, write with advance
    enter(20'hfe20, 4);
    press(set_memory_address_key);
    `CHECK(disp_left, 16'hfe20)
    `CHECK(disp_right, 16'h01df)
    reg_rd(REG_DISPLAY, rd);
    `CHECK(rd, 32'hfe2001df)
    enter(20'h0040, 4);
    press(write_memory_key);
    `CHECK(disp_right, 16'h0040)
    `CHECK(host_model_i.mem[16'hfe20], 16'h0040)
    enter(20'h1111, 4);
    press(write_memory_advance_key);
    `CHECK(host_model_i.mem[16'hfe20], 16'h1111)
    `CHECK(disp_left, 16'hfe22)
    `CHECK(disp_right, 16'h01dd)
    // read-back of a rom word shows what memory holds
    enter(20'hff80, 4);
    press(set_memory_address_key);
    enter(20'h1234, 4);
    press(write_memory_key);
    `CHECK(disp_right, 16'h007f)
    // bit field: show nine, write, show eight and sixteen
    for (int i = 0; i < 16; i++) host_model_i.bits[12'h0e0 + i] = W[i];
    enter(20'h90e0, 4);
    press(show_bitfield_key);
    `CHECK(disp_left, 16'h90e0)
    `CHECK(disp_right, {7'h00, W[8:0]})
    enter(20'h0005, 4);
    press(enter_bitfield_key);
    for (int i = 0; i < 16; i++) fv[i] = host_model_i.bits[12'h0e0 + i];
    `CHECK(fv, {W[15:9], 9'h005})
    enter(20'h80e0, 4);
    press(show_bitfield_key);
    `CHECK(disp_right, 16'h0500)
    enter(20'h00e0, 4);
    press(show_bitfield_key);
    `CHECK(disp_right, {W[15:9], 9'h005})
    // conversions both ways, with the signed limits
    for (int i = 0; i < 4; i++) begin
      press(CK[i]);
      enter(CI[i], CN[i]);
      press(CK[i]);
      if (i < 2) `CHECK(disp_right, CE[i][15:0])
      else `CHECK({disp_fifth, disp_right}, CE[i])
      if (i >= 2) `CHECK(disp_negative, (i == 2))
    end
    reg_rd(REG_DECIMAL, rd);
    `CHECK(rd, 32'h00032767)
    // run, halt, single step
    press(run_key);
    `CHECK(disp_run, 1'b1)
    press(halt_step_key);
    `CHECK(disp_run, 1'b0)
    `CHECK(disp_left, 16'hfe02)
    `CHECK(disp_right, 16'h01fd)
    press(halt_step_key);
    `CHECK(disp_left, 16'hfe04)
    `CHECK(disp_right, 16'h01fb)
    close_out();
  end
endmodule
